// >>> flash_protect_pkg.sv
// Purpose: shared constants for the flash block protection logic
// Assumes: 16-bit flash addresses, byte-wide protect value
// Notes:   register offsets are for the plain register port
package flash_protect_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 8;
   localparam logic [7:0]  PROT_ALL_ONES   = 8'hFF;
   localparam logic [1:0]  START_HIGH_BITS = 2'h3;
   localparam logic [5:0]  START_LOW_BITS  = 6'h00;
   localparam logic [15:0] PROTECT_BYTE_ADDR = 16'hFFBE;
   localparam logic [15:0] FLASH_BASE_ADDR = 16'hEE00;
   // register port offsets
   localparam logic [3:0]  CTRL_OFS        = 4'h0;
   localparam logic [3:0]  PROT_OFS        = 4'h1;
   localparam logic [3:0]  STAT_OFS        = 4'h2;
   // control field positions
   localparam int          PGM_BIT         = 0;
   localparam int          ERASE_BIT       = 1;
   localparam int          MASS_BIT        = 2;
   localparam int          HIGH_VOLTAGE_ENABLE_BIT        = 3;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
endpackage

// >>> flash_block_protection.sv
// Purpose: flash control bits with block protection gating
// Assumes: protect byte value comes from the flash array image
// Notes:   array write port models program, erase and mass erase requests
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - protect byte all zeros refuses every program and erase except at the protect byte with test high voltage.
// - protect byte all ones permits program and erase everywhere except the protect byte, which still needs test high voltage.
// - non-FF value blocks operations on protected range, and on protect byte unless test high voltage is present.
// - mass erase disabled whenever protect byte differs from all ones, unless mass is set in the same write that sets high voltage enable.
// - protect byte alterable only with test high voltage on interrupt pin.
// - test high voltage at reset also qualifies monitor mode entry.
// - protect byte lives in flash, changed only by programming sequence.
// - protect byte survives reset; factory value all ones.
// - start address is 11, protect bits, then six zeros.
// - addresses from start up to top are protected.
// - start address lies on 64-byte boundaries only.
// - small protect values protect the whole array.
// - value FE protects top 128 bytes incl. trim byte and vectors.
// - high voltage enable ignored when target address is protected.
// - high voltage enable settable only with program or erase already selected before that write.
// - program and erase selects never both one.
module flash_block_protection
   import flash_protect_pkg::*;
#(
   parameter logic [7:0] FACTORY_VALUE = 8'hFF
) (
   input  wire logic                          ref_clk_i,
   input  wire logic                          reset_n_i,
   input  wire logic [3:0]                    reg_addr_i,
   input  wire logic [7:0]                    reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic      [7:0]                    reg_rdata_o,
   input  wire logic                          flash_wr_i,
   input  wire logic [flash_protect_pkg::ADDR_W-1:0] flash_addr_i,
   input  wire logic [7:0]                    flash_wdata_i,
   input  wire logic                          test_high_voltage_i,
   output logic                               high_voltage_enable_o,
   output logic                               program_select_o,
   output logic                               erase_select_o,
   output logic                               mass_select_o,
   output logic                               array_program_o,
   output logic                               array_erase_o,
   output logic [flash_protect_pkg::ADDR_W-1:0] array_addr_o,
   output logic [7:0]                         array_data_o,
   output logic                               monitor_mode_o,
   output logic [7:0]                         protect_start_byte_o
);
   import flash_protect_pkg::*;

   typedef struct packed {
      logic        program_select;
      logic        erase;
      logic        mass;
      logic        high_voltage_enable;
      logic        prot_read;
      logic        addr_latched;
      logic [15:0] op_addr;
      logic        prog;
      logic        era;
      logic [15:0] arr_addr;
      logic [7:0]  arr_data;
      logic [7:0]  rdata;
      logic        monitor;
      logic        mon_taken;
   } state_s;

   // protect byte is nonvolatile: no reset, factory value at power up
   logic [7:0] protect_start_byte_ff = FACTORY_VALUE;
   logic       rst_n;
   // synchronisers kept apart: the pin copy must not be cleared by the reset it qualifies
   logic [1:0] rst_sync_ff;
   logic [1:0] tst_sync_ff;
   state_s     st_ff;
   state_s     nxt_st;

   function automatic logic [15:0] start_addr(input logic [7:0] v);
      start_addr = {START_HIGH_BITS, v, START_LOW_BITS};
   endfunction

   function automatic logic is_protected(input logic [15:0] a, input logic [7:0] v);
      // all zeros and small values fall at or below the array base
      if (v == PROT_ALL_ONES)
         is_protected = 1'b0;
      else
         is_protected = (a >= start_addr(v)) || (a == PROTECT_BYTE_ADDR);
   endfunction

   // protect byte itself is reachable only with the test voltage present
   function automatic logic write_blocked(input logic [15:0] a, input logic [7:0] v,
                                          input logic t);
      if (a == PROTECT_BYTE_ADDR)
         write_blocked = !t;
      else
         write_blocked = is_protected(a, v);
   endfunction

   assign rst_n = rst_sync_ff[1];

   logic target_prot;
   logic tst_ok;
   assign tst_ok = tst_sync_ff[1];
   // outside mass erase, blocking compares the latched address: the first write, then each allowed program write
   assign target_prot = st_ff.mass ? (protect_start_byte_ff != PROT_ALL_ONES)
                      : write_blocked(st_ff.op_addr, protect_start_byte_ff, tst_ok);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.prog = 1'b0;
      nxt_st.era = 1'b0;
      nxt_st.rdata = 8'h00;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            CTRL_OFS: nxt_st.rdata = {4'h0, st_ff.high_voltage_enable, st_ff.mass, st_ff.erase, st_ff.program_select};
            PROT_OFS: begin
               nxt_st.rdata = protect_start_byte_ff;
               nxt_st.prot_read = st_ff.program_select | st_ff.erase;
            end
            STAT_OFS: nxt_st.rdata = {5'h00, st_ff.monitor, st_ff.addr_latched, target_prot};
            default:  nxt_st.rdata = 8'h00;
         endcase
      end
      if (reg_wr_i && reg_addr_i == CTRL_OFS) begin
         nxt_st.mass = reg_wdata_i[MASS_BIT];
         // interlock: a write asking for both keeps neither new
         if (!(reg_wdata_i[PGM_BIT] && reg_wdata_i[ERASE_BIT])) begin
            nxt_st.program_select   = reg_wdata_i[PGM_BIT] & !st_ff.erase;
            nxt_st.erase = reg_wdata_i[ERASE_BIT] & !st_ff.program_select;
         end
         if (!reg_wdata_i[HIGH_VOLTAGE_ENABLE_BIT])
            nxt_st.high_voltage_enable = 1'b0;
         else if ((st_ff.program_select || st_ff.erase) && st_ff.prot_read
                  && st_ff.addr_latched && !target_prot) begin
            nxt_st.high_voltage_enable = 1'b1;
            // erase fires once, on the edge that turns high voltage on
            nxt_st.era = st_ff.erase & !st_ff.high_voltage_enable;
         end
         if (!nxt_st.program_select && !nxt_st.erase) begin
            nxt_st.prot_read = 1'b0;
            nxt_st.addr_latched = 1'b0;
         end
      end
      if (flash_wr_i && (st_ff.program_select || st_ff.erase)) begin
         if (!st_ff.addr_latched) begin
            nxt_st.addr_latched = 1'b1;
            nxt_st.op_addr = flash_addr_i;
         end else if (st_ff.high_voltage_enable && !target_prot) begin
            // later program writes must stay inside the allowed range
            if (st_ff.program_select && !write_blocked(flash_addr_i, protect_start_byte_ff, tst_ok)) begin
               nxt_st.prog = 1'b1;
               nxt_st.op_addr = flash_addr_i;
            end
         end
         nxt_st.arr_addr = flash_addr_i;
         nxt_st.arr_data = flash_wdata_i;
      end
      // monitor qualification captured after reset release
      if (!st_ff.mon_taken) begin
         nxt_st.monitor = tst_sync_ff[1];
         nxt_st.mon_taken = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   // no reset: the pin level must already be settled when reset lifts
   always_ff @(posedge ref_clk_i) begin
      tst_sync_ff <= {tst_sync_ff[0], test_high_voltage_i};
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_ff.program_select          <= CTRL_RESET[PGM_BIT];
         st_ff.erase        <= CTRL_RESET[ERASE_BIT];
         st_ff.mass         <= CTRL_RESET[MASS_BIT];
         st_ff.high_voltage_enable         <= CTRL_RESET[HIGH_VOLTAGE_ENABLE_BIT];
         st_ff.prot_read    <= 1'b0;
         st_ff.addr_latched <= 1'b0;
         st_ff.op_addr      <= 16'h0000;
         st_ff.prog         <= 1'b0;
         st_ff.era          <= 1'b0;
         st_ff.arr_addr     <= 16'h0000;
         st_ff.arr_data     <= 8'h00;
         st_ff.rdata        <= 8'h00;
         st_ff.monitor      <= 1'b0;
         st_ff.mon_taken    <= 1'b0;
      end else begin
         st_ff.program_select          <= nxt_st.program_select;
         st_ff.erase        <= nxt_st.erase;
         st_ff.mass         <= nxt_st.mass;
         st_ff.high_voltage_enable         <= nxt_st.high_voltage_enable;
         st_ff.prot_read    <= nxt_st.prot_read;
         st_ff.addr_latched <= nxt_st.addr_latched;
         st_ff.op_addr      <= nxt_st.op_addr;
         st_ff.prog         <= nxt_st.prog;
         st_ff.era          <= nxt_st.era;
         st_ff.arr_addr     <= nxt_st.arr_addr;
         st_ff.arr_data     <= nxt_st.arr_data;
         st_ff.rdata        <= nxt_st.rdata;
         st_ff.monitor      <= nxt_st.monitor;
         st_ff.mon_taken    <= nxt_st.mon_taken;
      end
   end

   // protect byte changes only through an allowed array program or erase
   always_ff @(posedge ref_clk_i) begin
      if (st_ff.prog && st_ff.arr_addr == PROTECT_BYTE_ADDR && tst_ok)
         protect_start_byte_ff <= protect_start_byte_ff & st_ff.arr_data;
      else if (st_ff.era && tst_ok && !st_ff.mass
               && st_ff.op_addr[15:6] == PROTECT_BYTE_ADDR[15:6])
         protect_start_byte_ff <= PROT_ALL_ONES;
      else if (st_ff.era && st_ff.mass && protect_start_byte_ff == PROT_ALL_ONES)
         protect_start_byte_ff <= PROT_ALL_ONES;
   end

   assign reg_rdata_o           = st_ff.rdata;
   assign high_voltage_enable_o = st_ff.high_voltage_enable;
   assign program_select_o      = st_ff.program_select;
   assign erase_select_o        = st_ff.erase;
   assign mass_select_o         = st_ff.mass;
   assign array_program_o       = st_ff.prog;
   assign array_erase_o         = st_ff.era;
   assign array_addr_o          = st_ff.arr_addr;
   assign array_data_o          = st_ff.arr_data;
   assign monitor_mode_o        = st_ff.monitor;
   assign protect_start_byte_o  = protect_start_byte_ff;
endmodule

// >>> flash_protect_monitor.sv
// Purpose: port checker for flash block protection
// Assumes: sees only the top module ports
// Notes:   range checked on the prior protect value, it may move with the pulse
`timescale 1ns/1ps
module flash_protect_monitor (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        flash_wr_i,
   input  wire logic [15:0] flash_addr_i,
   input  wire logic [7:0]  flash_wdata_i,
   input  wire logic        high_voltage_enable_o,
   input  wire logic        program_select_o,
   input  wire logic        erase_select_o,
   input  wire logic        mass_select_o,
   input  wire logic        array_program_o,
   input  wire logic        array_erase_o,
   input  wire logic [15:0] array_addr_o,
   input  wire logic [7:0]  array_data_o,
   input  wire logic [7:0]  protect_start_byte_o
);
   import flash_protect_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   sel_lock_a: assert property (!(program_select_o && erase_select_o))
      else $error("program and erase selected together");
   high_voltage_enable_sel_a: assert property ($rose(high_voltage_enable_o) |-> program_select_o || erase_select_o)
      else $error("high voltage without a select");
   mass_lock_a: assert property ((high_voltage_enable_o || array_erase_o) && mass_select_o
      |-> protect_start_byte_o == 8'hFF) else $error("mass erase while protected");
   prot_range_a: assert property (array_program_o && array_addr_o != PROTECT_BYTE_ADDR
      && $past(protect_start_byte_o) != 8'hFF
      |-> array_addr_o < {2'b11, $past(protect_start_byte_o), 6'h00})
      else $error("program inside protected range");
   all_locked_a: assert property (protect_start_byte_o == 8'h00
      && $past(protect_start_byte_o) == 8'h00
      |-> !array_program_o || array_addr_o == PROTECT_BYTE_ADDR)
      else $error("program with all blocks locked");
   pulse_cause_a: assert property (array_program_o |-> $past(flash_wr_i)
      && array_addr_o == $past(flash_addr_i) && array_data_o == $past(flash_wdata_i))
      else $error("program pulse without matching flash write");
   prog_hv_a: assert property (array_program_o |-> program_select_o && high_voltage_enable_o)
      else $error("program pulse without select and high voltage");
   nv_change_a: assert property ($changed(protect_start_byte_o)
      |-> array_program_o || $past(array_program_o) || $past(array_program_o, 2)
      || $past(array_erase_o)) else $error("protect byte changed without programming");
   erase_hv_a: assert property (array_erase_o |-> erase_select_o && high_voltage_enable_o)
      else $error("erase pulse without select and high voltage");
endmodule
bind flash_block_protection flash_protect_monitor mon (.ref_clk_i, .reset_n_i, .flash_wr_i,
   .flash_addr_i, .flash_wdata_i, .high_voltage_enable_o, .program_select_o, .erase_select_o,
   .mass_select_o, .array_program_o, .array_erase_o, .array_addr_o, .array_data_o,
   .protect_start_byte_o);

// >>> cpu_flash_driver.sv
// Purpose: cpu side issuing register and flash write cycles
// Assumes: slave never stalls, read data one cycle after strobe
// Notes:   released data and flash address lines show the inverse of the last value; addr_o keeps its value
`timescale 1ns/1ps
module cpu_flash_driver (
   input  wire logic        clk_i,
   input  wire logic [7:0]  rdata_i,
   output logic      [3:0]  addr_o,
   output logic      [7:0]  wdata_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic             fwr_o,
   output logic      [15:0] faddr_o,
   output logic      [7:0]  fdata_o
);
   initial {addr_o, wdata_o, wr_o, rd_o, fwr_o, faddr_o, fdata_o} = '0;
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask
   // next address follows at once, far inside the byte program time
   task automatic fw(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      faddr_o <= a;
      fdata_o <= d;
      fwr_o <= 1'b1;
      @(posedge clk_i);
      fwr_o <= 1'b0;
      faddr_o <= ~a;
      fdata_o <= ~d;
   endtask
endmodule

// >>> flash_block_protection_bench.sv
// Purpose: self-checking bench for flash block protection
// Assumes: cpu_flash_driver issues every bus cycle
// Notes:   the model tracks the protect byte on its own
`timescale 1ns/1ps
module flash_block_protection_bench;
   import flash_protect_pkg::*;
   logic        ref_clk = 0;
   logic        reset_n = 0;
   logic        tv = 0;
   logic [7:0]  p = 8'hFF;
   logic [31:0] rs = 32'h2C41;
   logic [15:0] bnd [4] = '{16'hEE3F, 16'hEE40, 16'hFFBE, 16'hEE00};
   logic [7:0]  sel [3] = '{8'h01, 8'h02, 8'h06};
   logic [15:0] a;
   int          n_fail = 0;
   int          checked = 0;
   wire  [3:0]  ra;
   wire  [7:0]  rw, rr, fd, ad, pb;
   wire  [15:0] fa, aa;
   wire         wr, rd, fw, high_voltage_enable, ps, es, ms, ap, ae, mm;
   always #4 ref_clk = ~ref_clk;
   cpu_flash_driver cpu (.clk_i(ref_clk), .rdata_i(rr), .addr_o(ra), .wdata_o(rw), .wr_o(wr),
      .rd_o(rd), .fwr_o(fw), .faddr_o(fa), .fdata_o(fd));
   flash_block_protection dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .reg_addr_i(ra),
      .reg_wdata_i(rw), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rr), .flash_wr_i(fw),
      .flash_addr_i(fa), .flash_wdata_i(fd), .test_high_voltage_i(tv),
      .high_voltage_enable_o(high_voltage_enable), .program_select_o(ps), .erase_select_o(es),
      .mass_select_o(ms), .array_program_o(ap), .array_erase_o(ae), .array_addr_o(aa),
      .array_data_o(ad), .monitor_mode_o(mm), .protect_start_byte_o(pb));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   function automatic logic blk(input logic [15:0] a, input logic [7:0] s);
      if (s == 8'h06 && p != 8'hFF) return 1'b1;
      if (a == PROTECT_BYTE_ADDR) return !tv;
      if (p == 8'hFF) return 1'b0;
      return a >= {2'b11, p, 6'h00};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      if (n_fail == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] s);
      logic [7:0] r;
      logic       b;
      b = blk(a, s);
      cpu.wr(CTRL_OFS, s);
      cpu.rd(PROT_OFS, r);
      chk("protect read", p, r);
      cpu.fw(a, d);
      cpu.wr(CTRL_OFS, s | 8'h08);
      #1 chk("high_voltage_enable", !b, high_voltage_enable);
      chk("erase pulse", s != 8'h01 && !b, ae);
      chk("mass select", s[2], ms);
      if (s == 8'h01) begin
         cpu.fw(a, d);
         #1 chk("program pulse", !b, ap);
         if (!b) chk("program addr", a, aa);
         if (!b && a == PROTECT_BYTE_ADDR) p = p & d;
      end
      cpu.wr(CTRL_OFS, 8'h00);
   endtask
   task automatic set_tv(input logic v);
      @(posedge ref_clk);
      tv <= v;
      repeat (4) @(posedge ref_clk);
   endtask
   initial begin
      #200000;
      n_fail++;
      complete_run;
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("protect", 8'hFF, pb);
      chk("monitor", 0, mm);
      cpu.wr(CTRL_OFS, 8'h03);
      #1 chk("selects", 0, {ps, es});
      cpu.wr(CTRL_OFS, 8'h08);
      #1 chk("high_voltage_enable alone", 0, high_voltage_enable);
      // few short sequences keep every row far from hv time and cycle limits
      for (int i = 0; i < 36; i++) begin
         if (i == 12 || i == 24) begin
            set_tv(1'b1);
            op(PROTECT_BYTE_ADDR, i == 12 ? 8'hB9 : 8'h00, 8'h01);
            chk("protect", p, pb);
            set_tv(1'b0);
         end
         rs = xs(rs);
         a = (i % 4 == 0) ? bnd[(i / 4) % 4] : 16'hEE00 + 16'(rs[15:0] % 16'h11FF);
         op(i % 3 == 2 ? 16'hEE00 : a, rs[23:16], sel[i % 3]);
      end
      @(posedge ref_clk);
      tv <= 1'b1;
      reset_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk("monitor", 1, mm);
      chk("protect", p, pb);
      complete_run;
   end
endmodule
